// ---- hdl/bot_timer.v ----
// Boolean output timer: four expression-driven outputs with delay and one-shot duration.
`timescale 1ns/1ps
`default_nettype none
`include "bot_regs.vh"
module bot_timer (
  // Clock and reset.
  input wire i_clock,
  input wire i_rst_b,
  // Field inputs and virtual inputs written by the controller.
  input wire [7:0] i_real_in,
  input wire [7:0] i_virt_in,
  // Boolean control mode enable, one bit per output.
  input wire [3:0] i_bool_mode,
  // Operands A, B, C per output, five bits each, output 0 in the low bits.
  input wire [19:0] i_opnd_a,
  input wire [19:0] i_opnd_b,
  input wire [19:0] i_opnd_c,
  // Operators per output, two bits each.
  input wire [7:0] i_opr_1,
  input wire [7:0] i_opr_2,
  // Delay and duration in ms per output, ten bits each.
  input wire [39:0] i_delay_ms,
  input wire [39:0] i_dur_ms,
  // Controller-image drive used when an output is not in Boolean mode.
  input wire [3:0] i_direct_out,
  // Output drives and expression state.
  output reg [3:0] o_out,
  output reg [3:0] o_expr
);
  // The tick count is an integer expression, so it is cut to the prescaler width on purpose.
  localparam integer TICK_LAST_I = `BOT_TICK_CYC - 1;
  localparam [`BOT_PRE_W-1:0] TICK_LAST = TICK_LAST_I[`BOT_PRE_W-1:0];
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_DELAY = 4'h2;
  localparam [3:0] ST_ON = 4'h4;
  localparam [3:0] ST_HOLD = 4'h8;

  // Field inputs come from pins, so they pass two flip-flops first.
  reg [7:0] real_s1_q;
  reg [7:0] real_s2_q;
  reg [7:0] virt_q;
  reg [`BOT_PRE_W-1:0] pre_q;
  reg tick_q;

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      real_s1_q <= 8'h00;
      real_s2_q <= 8'h00;
      virt_q <= 8'h00;
    end else begin
      real_s1_q <= i_real_in;
      real_s2_q <= real_s1_q;
      virt_q <= i_virt_in;
    end
  end

  // One tick every millisecond shared by all channels.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_q <= {`BOT_PRE_W{1'b0}};
      tick_q <= 1'b0;
    end else if (pre_q == TICK_LAST) begin
      pre_q <= {`BOT_PRE_W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      pre_q <= pre_q + {{(`BOT_PRE_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end

  // Operand select: code 0 is none, else bits 4:3 pick the source and 2:0 the input.
  function opnd_val;
    input [4:0] sel;
    input [7:0] rin;
    input [7:0] vin;
    begin
      case (sel[4:3])
        `BOT_OPND_REAL: opnd_val = rin[sel[2:0]];
        `BOT_OPND_RINV: opnd_val = ~rin[sel[2:0]];
        `BOT_OPND_VIRT: opnd_val = vin[sel[2:0]];
        default: opnd_val = (sel == `BOT_OPND_NONE) ? 1'b0 : ~vin[sel[2:0]];
      endcase
    end
  endfunction

  // A none operator passes the left side unchanged, so A and A x B forms work.
  function opr_val;
    input [1:0] op;
    input l;
    input r;
    begin
      case (op)
        `BOT_OPR_OR: opr_val = l | r;
        `BOT_OPR_AND: opr_val = l & r;
        `BOT_OPR_XOR: opr_val = l ^ r;
        default: opr_val = l;
      endcase
    end
  endfunction

  reg [3:0] expr_c;
  integer k;
  always @* begin
    expr_c = 4'h0;
    for (k = 0; k < `BOT_NCH; k = k + 1) begin
      // An all-none expression evaluates FALSE, keeping the output off.
      expr_c[k] = opr_val(i_opr_2[2*k +: 2],
        opr_val(i_opr_1[2*k +: 2], opnd_val(i_opnd_a[5*k +: 5], real_s2_q, virt_q),
          opnd_val(i_opnd_b[5*k +: 5], real_s2_q, virt_q)),
        opnd_val(i_opnd_c[5*k +: 5], real_s2_q, virt_q));
    end
  end

  genvar g;
  generate
    for (g = 0; g < `BOT_NCH; g = g + 1) begin : ch
      wire [`BOT_TIME_W-1:0] dly = (i_delay_ms[10*g +: 10] > `BOT_TIME_MAX) ? `BOT_TIME_MAX :
        i_delay_ms[10*g +: 10];
      wire [`BOT_TIME_W-1:0] dur = (i_dur_ms[10*g +: 10] > `BOT_TIME_MAX) ? `BOT_TIME_MAX :
        i_dur_ms[10*g +: 10];
      wire ex = expr_c[g];
      reg ex_q;
      reg [3:0] st_q;
      reg [3:0] st_d;
      reg [`BOT_TIME_W-1:0] cnt_q;
      reg [`BOT_TIME_W-1:0] cnt_d;
      wire rise = ex & ~ex_q;
      wire one_shot = (dur != {`BOT_TIME_W{1'b0}});
      wire cnt_done = tick_q && (cnt_q == {{(`BOT_TIME_W-1){1'b0}}, 1'b1});

      // The counter reloads on entry to each timed state and counts down on ticks.
      // Timing is quantised to the shared tick, so a step may be up to 1 ms short.
      always @* begin
        st_d = st_q;
        cnt_d = (tick_q && cnt_q != {`BOT_TIME_W{1'b0}}) ?
          cnt_q - {{(`BOT_TIME_W-1){1'b0}}, 1'b1} : cnt_q;
        case (st_q)
          ST_IDLE: begin
            if (rise) begin
              if (dly != {`BOT_TIME_W{1'b0}}) begin
                st_d = ST_DELAY;
                cnt_d = dly;
              end else if (one_shot) begin
                st_d = ST_ON;
                cnt_d = dur;
              end else begin
                st_d = ST_HOLD;
              end
            end else if (ex && !one_shot && dly == {`BOT_TIME_W{1'b0}}) begin
              st_d = ST_HOLD;
            end
          end
          ST_DELAY: begin
            if (!one_shot && !ex) begin
              st_d = ST_IDLE;
            end else if (cnt_done) begin
              if (one_shot) begin
                st_d = ST_ON;
                cnt_d = dur;
              end else begin
                st_d = ST_HOLD;
              end
            end
          end
          ST_ON: begin
            if (cnt_done) begin
              st_d = ST_IDLE;
            end
          end
          ST_HOLD: begin
            if (!ex) begin
              st_d = ST_IDLE;
            end
          end
          default: st_d = ST_IDLE;
        endcase
      end

      always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
          st_q <= ST_IDLE;
          cnt_q <= {`BOT_TIME_W{1'b0}};
          ex_q <= 1'b0;
          o_out[g] <= 1'b0;
          o_expr[g] <= 1'b0;
        end else begin
          st_q <= st_d;
          cnt_q <= cnt_d;
          ex_q <= ex;
          o_expr[g] <= ex;
          if (i_bool_mode[g]) begin
            o_out[g] <= (st_d == ST_ON) | (st_d == ST_HOLD);
          end else begin
            o_out[g] <= i_direct_out[g];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- shared/bot_regs.vh ----
// Constants for the Boolean output timer: encodings and timing counts.
`ifndef BOT_REGS_VH
`define BOT_REGS_VH
`define BOT_NCH 4
`define BOT_OPND_W 5
`define BOT_OPND_NONE 5'h00
`define BOT_OPND_REAL 2'h1
`define BOT_OPND_RINV 2'h2
`define BOT_OPND_VIRT 2'h3
`define BOT_OPND_VINV 2'h0
`define BOT_OPR_W 2
`define BOT_OPR_NONE 2'h0
`define BOT_OPR_OR 2'h1
`define BOT_OPR_AND 2'h2
`define BOT_OPR_XOR 2'h3
`define BOT_TIME_W 10
`define BOT_TIME_MAX 10'h3E8
`define BOT_CLK_HZ 10000000
`define BOT_TICK_MS 1
`define BOT_TICK_CYC ((`BOT_CLK_HZ / 1000) * `BOT_TICK_MS)
`define BOT_PRE_W 14
`endif

// ---- tb/bot_ctrl.sv ----
// Controller model that writes the virtual inputs.
`timescale 1ns/1ps
`default_nettype none
module bot_ctrl (
  // Clock and wanted image.
  input wire logic i_clock,
  input wire logic [7:0] i_image,
  // Virtual input drive.
  output var logic [7:0] o_virt
);
  initial o_virt = 8'h00;
  // Refreshed once a cycle, as a controller scan would.
  always @(negedge i_clock) o_virt <= i_image;
endmodule
`default_nettype wire

// ---- tb/bot_timer_props.sv ----
// Checker of the Boolean output timer ports.
`timescale 1ns/1ps
`default_nettype none
module bot_chk (
  // Watched ports.
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [3:0] i_bool_mode,
  input wire logic [19:0] i_opnd_a,
  input wire logic [19:0] i_opnd_b,
  input wire logic [19:0] i_opnd_c,
  input wire logic [39:0] i_delay_ms,
  input wire logic [39:0] i_dur_ms,
  input wire logic [3:0] o_out,
  input wire logic [3:0] o_expr
);
  localparam int TK = 10000;
  int t_q;
  int h_q;
  wire [9:0] dl = i_delay_ms[9:0];
  wire [9:0] du = i_dur_ms[9:0];
  wire on0 = i_bool_mode[0];
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // Run lengths let the timed rules be judged without long repetitions.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t_q <= 0;
      h_q <= 0;
    end else begin
      t_q <= o_expr[0] ? t_q + 1 : 0;
      h_q <= o_out[0] ? h_q + 1 : 0;
    end
  end
  property p_mirror;
    (on0 && dl == 0 && du == 0) [*3] |-> o_out[0] == o_expr[0];
  endproperty
  a_mirror: assert property (p_mirror) else $error("output not mirroring");
  property p_fall;
    on0 && du == 0 && $fell(o_expr[0]) |-> ##[0:1] !o_out[0];
  endproperty
  a_fall: assert property (p_fall) else $error("output late off");
  property p_abandon;
    (on0 && du == 0 && !o_expr[0]) [*2] |-> !o_out[0];
  endproperty
  a_abandon: assert property (p_abandon) else $error("output on while false");
  property p_null;
    (i_opnd_a[4:0] == 5'h00 && i_opnd_b[4:0] == 5'h00 && i_opnd_c[4:0] == 5'h00) [*3] |-> !o_expr[0];
  endproperty
  a_null: assert property (p_null) else $error("null expression true");
  property p_hold;
    on0 && du == 0 && dl != 0 && $rose(o_out[0]) |-> t_q >= (dl - 1) * TK;
  endproperty
  a_hold: assert property (p_hold) else $error("output on too early");
  property p_len;
    on0 && du != 0 && $fell(o_out[0]) |-> h_q >= (du - 1) * TK && h_q <= du * TK + 1;
  endproperty
  a_len: assert property (p_len) else $error("pulse length wrong");
  property p_keep;
    on0 && du != 0 && $rose(o_out[0]) |=> o_out[0] [*8];
  endproperty
  a_keep: assert property (p_keep) else $error("pulse cut short");
  property p_wait;
    on0 && du == 0 && dl > 1 && $rose(o_expr[0]) |-> !o_out[0] [*8];
  endproperty
  a_wait: assert property (p_wait) else $error("delay skipped");
endmodule
bind bot_timer bot_chk i_chk (.i_clock, .i_rst_b, .i_bool_mode, .i_opnd_a, .i_opnd_b, .i_opnd_c,
  .i_delay_ms, .i_dur_ms, .o_out, .o_expr);
`default_nettype wire

// ---- tb/tb_bot_timer.sv ----
// Self-checking bench of the Boolean output timer.
`timescale 1ns/1ps
`default_nettype none
module tb_bot_timer;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] rin = 8'h00, img = 8'h00, o1 = 8'h00, o2 = 8'h00;
  logic [19:0] oa = 20'h0, ob = 20'h0, oc = 20'h0;
  logic [39:0] dly = 40'h0, dur = 40'h0;
  logic [3:0] ev;
  logic [3:0] bm = 4'hF, dout = 4'h0;
  logic pv;
  wire [7:0] virt;
  wire [3:0] out, expr;
  int n_mismatch = 0, n_tests = 0, cyc = 0, rs = 0, hi = 0;
  bot_ctrl i_ctrl (.i_clock, .i_image(img), .o_virt(virt));
  bot_timer i_dut (.i_clock, .i_rst_b, .i_real_in(rin), .i_virt_in(virt), .i_bool_mode(bm),
    .i_opnd_a(oa), .i_opnd_b(ob), .i_opnd_c(oc), .i_opr_1(o1), .i_opr_2(o2), .i_delay_ms(dly),
    .i_dur_ms(dur), .i_direct_out(dout), .o_out(out), .o_expr(expr));
  initial forever #50 i_clock = ~i_clock;
  function automatic logic opv(input logic [4:0] s);
    case (s[4:3])
      2'h1: return rin[s[2:0]];
      2'h2: return !rin[s[2:0]];
      2'h3: return virt[s[2:0]];
      default: return s != 5'h00 && !virt[s[2:0]];
    endcase
  endfunction
  function automatic logic opf(input logic [1:0] o, input logic l, input logic r);
    case (o)
      2'h1: return l | r;
      2'h2: return l & r;
      2'h3: return l ^ r;
      default: return l;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic win(input int n);
    pv = out[0];
    repeat (n) begin
      @(negedge i_clock);
      rs += int'(out[0] && !pv);
      hi += int'(out[0]);
      pv = out[0];
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      complete_run;
    end
  end
  initial begin
    void'($urandom(32'hc226));
    win(4);
    i_rst_b <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      rin <= 8'($urandom);
      img <= 8'($urandom);
      {oa, ob, oc} <= (k == 0) ? 60'h0 : 60'({$urandom, $urandom});
      {o1, o2} <= 16'($urandom);
      win(6);
      for (int c = 0; c < 4; c++)
        ev[c] = opf(o2[2*c+:2], opf(o1[2*c+:2], opv(oa[5*c+:5]), opv(ob[5*c+:5])), opv(oc[5*c+:5]));
      chk("expression", ev, expr);
      chk("mirror", ev, out);
    end
    // Outside Boolean mode the outputs must follow the direct drive instead.
    for (int k = 0; k < 4; k++) begin
      bm <= 4'h0;
      dout <= 4'($urandom);
      win(3);
      chk("direct", dout, out);
    end
    bm <= 4'hF;
    // Expression is virtual input zero alone; settle before arming timers.
    {oa, ob, oc, o1, o2} <= {20'h18, 56'h0};
    img <= 8'h00;
    win(10);
    dly <= 40'h1;
    dur <= 40'h1;
    win(30);
    for (int k = 0; k < 2; k++) begin
      rs = 0;
      hi = 0;
      img <= 8'h01;
      win(10);
      img <= 8'h00;
      win(200);
      img <= 8'h01;
      win(10);
      img <= 8'h00;
      win(21000);
      chk("pulses", 4'h1, 4'(rs));
      chk("pulse_len", 4'h1, {3'h0, hi >= 1 && hi <= 10001});
    end
    dly <= 40'h2;
    dur <= 40'h0;
    win(30);
    rs = 0;
    hi = 0;
    img <= 8'h01;
    win(3000);
    img <= 8'h00;
    win(10);
    chk("short_true", 4'h0, 4'(rs));
    img <= 8'h01;
    win(25000);
    chk("held_true", 4'h1, 4'(rs));
    chk("delay_len", 4'h1, {3'h0, hi >= 4990 && hi <= 15010});
    img <= 8'h00;
    win(4);
    chk("off", 4'h0, {3'h0, out[0]});
    complete_run;
  end
endmodule
`default_nettype wire
